//--- core/mpcp_pkg.sv
// constants and register map of the module pin configuration port
package mpcp_pkg;
  localparam int NPIN   = 12;
  localparam int ADDR_W = 8;

  // system clock and glitch filter time
  localparam int CLK_NS   = 50;
  localparam int FILT_NS  = 150;
  localparam int FILT_CYC = (FILT_NS + CLK_NS - 1) / CLK_NS;

  // register byte offsets
  localparam logic [7:0] OFS_MODE   = 8'h00;
  localparam logic [7:0] OFS_PULL   = 8'h04;
  localparam logic [7:0] OFS_DRIVE  = 8'h08;
  localparam logic [7:0] OFS_DOUT   = 8'h0C;
  localparam logic [7:0] OFS_FILT   = 8'h10;
  localparam logic [7:0] OFS_EDGE   = 8'h14;
  localparam logic [7:0] OFS_LEVEL  = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_MASK   = 8'h20;
  localparam logic [7:0] OFS_DEBUG  = 8'h24;
  localparam logic [7:0] OFS_LOWPWR = 8'h28;

  // two-bit per-pin field codes
  localparam logic [1:0] MODE_TRI  = 2'h0;
  localparam logic [1:0] MODE_IN   = 2'h1;
  localparam logic [1:0] MODE_PP   = 2'h2;
  localparam logic [1:0] MODE_OD   = 2'h3;
  localparam logic [1:0] PULL_OFF  = 2'h0;
  localparam logic [1:0] PULL_UP   = 2'h1;
  localparam logic [1:0] PULL_DN   = 2'h2;
  localparam logic [1:0] DRV_0P5MA = 2'h0;
  localparam logic [1:0] DRV_2MA   = 2'h1;
  localparam logic [1:0] DRV_6MA   = 2'h2;
  localparam logic [1:0] DRV_20MA  = 2'h3;
  localparam logic [1:0] EDGE_OFF  = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // pin indices of the two debug pins
  localparam int PIN_DBG_DATA = 10;
  localparam int PIN_DBG_CLK  = 11;

  // reset values and bus answers
  localparam logic [23:0] RST_FIELD2 = 24'h00_0000;
  localparam logic [11:0] RST_FIELD1 = 12'h000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

//--- core/mpcp_pin_cell.sv
// one input pin: synchroniser, glitch filter and edge detector
`timescale 1ns/10ps
module mpcp_pin_cell #(
  parameter int FILT_LEN = mpcp_pkg::FILT_CYC
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       pin_in,
  input  wire logic       filt_en,
  input  wire logic [1:0] edge_sel,
  output logic            level,
  output logic            edge_evt
);
  import mpcp_pkg::*;

  initial begin
    if (FILT_LEN < 1 || FILT_LEN > 255) begin
      $error("FILT_LEN out of range");
    end
  end

  typedef struct packed {
    logic       s1;
    logic       s2;
    logic       lvl;
    logic [7:0] cnt;
    logic       evt;
  } mpcp_cell_s;

  mpcp_cell_s s;
  mpcp_cell_s next_s;
  logic       rise;
  logic       fall;

  always_comb begin
    next_s = s;
    next_s.s1 = pin_in;
    next_s.s2 = s.s1;
    // a change must persist FILT_LEN samples before it is believed
    if (!filt_en) begin
      next_s.lvl = s.s2;
      next_s.cnt = 8'h00;
    end else if (s.s2 == s.lvl) begin
      next_s.cnt = 8'h00;
    end else if (s.cnt == 8'(FILT_LEN - 1)) begin
      next_s.lvl = s.s2;
      next_s.cnt = 8'h00;
    end else begin
      next_s.cnt = s.cnt + 8'h01;
    end
    rise = next_s.lvl & ~s.lvl;
    fall = ~next_s.lvl & s.lvl;
    case (edge_sel)
      EDGE_RISE: next_s.evt = rise;
      EDGE_FALL: next_s.evt = fall;
      EDGE_BOTH: next_s.evt = rise | fall;
      default:   next_s.evt = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level    = s.lvl;
  assign edge_evt = s.evt;

  property p_filt_hold;
    @(posedge clk) disable iff (!reset_n)
      filt_en && s.lvl != s.s2 && s.cnt != 8'(FILT_LEN - 1) |=> s.lvl == $past(s.lvl);
  endproperty
  a_filt_hold: assert property (p_filt_hold) else $error("filter let a glitch through");

  property p_nofilt;
    @(posedge clk) disable iff (!reset_n)
      !filt_en |=> s.lvl == $past(s.s2);
  endproperty
  a_nofilt: assert property (p_nofilt) else $error("unfiltered level lags");
endmodule

//--- core/mpcp_top.sv
// module pin configuration port: twelve pins behind an AXI4-Lite register file
`timescale 1ns/10ps
// Overview of operation
// - each of twelve pins configured alone; all but the two debug pins start tristate after reset
// - per pin push-pull or open-drain, and pull-up, pull-down or none
// - per pin drive strength of 0.5, 2, 6 or 20 mA
// - input pins have a glitch filter switched per pin by software
// - input pins flag rising, falling or both edges as selected
// - an enabled edge wakes the block from low power and, if its mask bit is set, signals interrupt
// - pin configuration is kept unchanged across low-power entry and exit
// - configuration changes only by host commands; host sends them to change pins
// - low reset returns everything, pin configuration included, to initial state
// - after reset debug data pin belongs to debug, bidirectional, pulled up
// - after reset debug clock pin belongs to debug, input only, pulled down
// - a command releases both debug pins for other uses such as general I/O
module mpcp_top #(
  parameter int FILT_LEN = mpcp_pkg::FILT_CYC
) (
  input  wire logic                          clk,
  input  wire logic                          reset_n,
  input  wire logic [mpcp_pkg::ADDR_W-1:0]   awaddr,
  input  wire logic                          awvalid,
  output logic                               awready,
  input  wire logic [31:0]                   wdata,
  input  wire logic [3:0]                    wstrb,
  input  wire logic                          wvalid,
  output logic                               wready,
  output logic [1:0]                         bresp,
  output logic                               bvalid,
  input  wire logic                          bready,
  input  wire logic [mpcp_pkg::ADDR_W-1:0]   araddr,
  input  wire logic                          arvalid,
  output logic                               arready,
  output logic [31:0]                        rdata,
  output logic [1:0]                         rresp,
  output logic                               rvalid,
  input  wire logic                          rready,
  input  wire logic [mpcp_pkg::NPIN-1:0]     pin_in,
  output logic [mpcp_pkg::NPIN-1:0]          pin_out,
  output logic [mpcp_pkg::NPIN-1:0]          pin_oe,
  output logic [mpcp_pkg::NPIN-1:0]          pin_pull_up,
  output logic [mpcp_pkg::NPIN-1:0]          pin_pull_down,
  output logic [2*mpcp_pkg::NPIN-1:0]        pin_drive,
  input  wire logic                          swd_dio_out,
  input  wire logic                          swd_dio_oe,
  output logic                               swd_dio_in,
  output logic                               swd_clk_in,
  output logic                               low_power,
  output logic                               irq
);
  import mpcp_pkg::*;

  initial begin
    if (NPIN != 12 || ADDR_W != 8) begin
      $error("pin count or address width unsupported");
    end
  end

  typedef struct packed {
    logic                awready;
    logic                wready;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                aw_ok;
    logic                w_ok;
    logic [ADDR_W-1:0]   awaddr;
    logic [31:0]         wdata;
    logic [3:0]          wstrb;
    logic                arready;
    logic                rvalid;
    logic [1:0]          rresp;
    logic [31:0]         rdata;
    logic [2*NPIN-1:0]   mode;
    logic [2*NPIN-1:0]   pull;
    logic [2*NPIN-1:0]   drive;
    logic [NPIN-1:0]     dout;
    logic [NPIN-1:0]     filt;
    logic [2*NPIN-1:0]   edge_sel;
    logic [NPIN-1:0]     pend;
    logic [NPIN-1:0]     mask;
    logic                dbg_rel;
    logic                sleep;
    logic                irq;
    logic [NPIN-1:0]     pin_out;
    logic [NPIN-1:0]     pin_oe;
    logic [NPIN-1:0]     pull_up;
    logic [NPIN-1:0]     pull_dn;
    logic [2*NPIN-1:0]   pin_drv;
    logic                dio_in;
    logic                clk_in;
  } mpcp_state_s;

  mpcp_state_s       s;
  mpcp_state_s       next_s;
  logic [NPIN-1:0]   lvl;
  logic [NPIN-1:0]   evt;
  logic [NPIN-1:0]   ev;
  logic              wr_do;

  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = data[8*b +: 8];
      end
    end
    return r;
  endfunction

  // debug pins raise events only once released
  for (genvar i = 0; i < NPIN; i++) begin : g_pin
    mpcp_pin_cell #(
      .FILT_LEN (FILT_LEN)
    ) u_cell (
      .clk      (clk),
      .reset_n  (reset_n),
      .pin_in   (pin_in[i]),
      .filt_en  (s.filt[i]),
      .edge_sel (s.edge_sel[2*i +: 2]),
      .level    (lvl[i]),
      .edge_evt (evt[i])
    );
    assign ev[i] = evt[i] && s.mode[2*i +: 2] == MODE_IN
                   && (s.dbg_rel || i < PIN_DBG_DATA);
  end

  assign wr_do = s.aw_ok && s.w_ok && !s.bvalid;

  always_comb begin
    logic [31:0] wv;
    logic [1:0]  md;
    logic [1:0]  pl;
    wv = 32'h0000_0000;
    md = MODE_TRI;
    pl = PULL_OFF;
    next_s = s;
    // write address and data are taken in either order, then joined
    if (awvalid && s.awready) begin
      next_s.awaddr  = awaddr;
      next_s.aw_ok   = 1'b1;
      next_s.awready = 1'b0;
    end
    if (wvalid && s.wready) begin
      next_s.wdata  = wdata;
      next_s.wstrb  = wstrb;
      next_s.w_ok   = 1'b1;
      next_s.wready = 1'b0;
    end
    // the only path that changes pin configuration
    if (wr_do) begin
      next_s.bvalid = 1'b1;
      next_s.bresp  = RESP_OKAY;
      case ({s.awaddr[7:2], 2'b00})
        OFS_MODE: begin
          wv = wmerge({8'h00, s.mode}, s.wdata, s.wstrb);
          next_s.mode = wv[23:0];
        end
        OFS_PULL: begin
          wv = wmerge({8'h00, s.pull}, s.wdata, s.wstrb);
          next_s.pull = wv[23:0];
        end
        OFS_DRIVE: begin
          wv = wmerge({8'h00, s.drive}, s.wdata, s.wstrb);
          next_s.drive = wv[23:0];
        end
        OFS_DOUT: begin
          wv = wmerge({20'h0_0000, s.dout}, s.wdata, s.wstrb);
          next_s.dout = wv[11:0];
        end
        OFS_FILT: begin
          wv = wmerge({20'h0_0000, s.filt}, s.wdata, s.wstrb);
          next_s.filt = wv[11:0];
        end
        OFS_EDGE: begin
          wv = wmerge({8'h00, s.edge_sel}, s.wdata, s.wstrb);
          next_s.edge_sel = wv[23:0];
        end
        OFS_MASK: begin
          wv = wmerge({20'h0_0000, s.mask}, s.wdata, s.wstrb);
          next_s.mask = wv[11:0];
        end
        OFS_DEBUG: begin
          if (s.wstrb[0]) begin
            next_s.dbg_rel = s.wdata[0];
          end
        end
        OFS_LOWPWR: begin
          if (s.wstrb[0]) begin
            next_s.sleep = s.wdata[0];
          end
        end
        OFS_LEVEL, OFS_STATUS: begin
        end
        default: next_s.bresp = RESP_SLVERR;
      endcase
    end
    if (s.bvalid && bready) begin
      next_s.bvalid  = 1'b0;
      next_s.aw_ok   = 1'b0;
      next_s.w_ok    = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready  = 1'b1;
    end
    // reads answer one cycle after the address is taken
    if (arvalid && s.arready) begin
      next_s.arready = 1'b0;
      next_s.rvalid  = 1'b1;
      next_s.rresp   = RESP_OKAY;
      case ({araddr[7:2], 2'b00})
        OFS_MODE:   next_s.rdata = {8'h00, s.mode};
        OFS_PULL:   next_s.rdata = {8'h00, s.pull};
        OFS_DRIVE:  next_s.rdata = {8'h00, s.drive};
        OFS_DOUT:   next_s.rdata = {20'h0_0000, s.dout};
        OFS_FILT:   next_s.rdata = {20'h0_0000, s.filt};
        OFS_EDGE:   next_s.rdata = {8'h00, s.edge_sel};
        OFS_LEVEL:  next_s.rdata = {20'h0_0000, lvl};
        OFS_STATUS: begin
          next_s.rdata = {20'h0_0000, s.pend};
          next_s.pend  = RST_FIELD1;
        end
        OFS_MASK:   next_s.rdata = {20'h0_0000, s.mask};
        OFS_DEBUG:  next_s.rdata = {31'h0000_0000, s.dbg_rel};
        OFS_LOWPWR: next_s.rdata = {31'h0000_0000, s.sleep};
        default: begin
          next_s.rdata = 32'h0000_0000;
          next_s.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (s.rvalid && rready) begin
      next_s.rvalid  = 1'b0;
      next_s.arready = 1'b1;
    end
    // a new edge beats the read-clear of the same cycle
    next_s.pend = next_s.pend | ev;
    if (|ev) begin
      next_s.sleep = 1'b0;
    end
    next_s.irq = |(next_s.pend & next_s.mask);
    // sleep touches no configuration field, so pins hold across it
    for (int i = 0; i < NPIN; i++) begin
      md = next_s.mode[2*i +: 2];
      pl = next_s.pull[2*i +: 2];
      next_s.pin_out[i] = md == MODE_PP && next_s.dout[i];
      next_s.pin_oe[i]  = md == MODE_PP || (md == MODE_OD && !next_s.dout[i]);
      next_s.pull_up[i] = pl == PULL_UP;
      next_s.pull_dn[i] = pl == PULL_DN;
    end
    if (!next_s.dbg_rel) begin
      next_s.pin_out[PIN_DBG_DATA] = swd_dio_out;
      next_s.pin_oe[PIN_DBG_DATA]  = swd_dio_oe;
      next_s.pull_up[PIN_DBG_DATA] = 1'b1;
      next_s.pull_dn[PIN_DBG_DATA] = 1'b0;
      next_s.pin_out[PIN_DBG_CLK]  = 1'b0;
      next_s.pin_oe[PIN_DBG_CLK]   = 1'b0;
      next_s.pull_up[PIN_DBG_CLK]  = 1'b0;
      next_s.pull_dn[PIN_DBG_CLK]  = 1'b1;
    end
    next_s.pin_drv = next_s.drive;
    next_s.dio_in  = lvl[PIN_DBG_DATA];
    next_s.clk_in  = lvl[PIN_DBG_CLK];
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s          <= '0;
      s.awready  <= 1'b1;
      s.wready   <= 1'b1;
      s.arready  <= 1'b1;
      s.mode     <= RST_FIELD2;
      s.pull     <= RST_FIELD2;
      s.drive    <= RST_FIELD2;
      s.edge_sel <= RST_FIELD2;
      s.pull_up  <= 12'h400;
      s.pull_dn  <= 12'h800;
    end else begin
      s <= next_s;
    end
  end

  assign awready       = s.awready;
  assign wready        = s.wready;
  assign bresp         = s.bresp;
  assign bvalid        = s.bvalid;
  assign arready       = s.arready;
  assign rdata         = s.rdata;
  assign rresp         = s.rresp;
  assign rvalid        = s.rvalid;
  assign pin_out       = s.pin_out;
  assign pin_oe        = s.pin_oe;
  assign pin_pull_up   = s.pull_up;
  assign pin_pull_down = s.pull_dn;
  assign pin_drive     = s.pin_drv;
  assign swd_dio_in    = s.dio_in;
  assign swd_clk_in    = s.clk_in;
  assign low_power     = s.sleep;
  assign irq           = s.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_tristate;
    s.mode[1:0] == MODE_TRI |-> !pin_oe[0] && !pin_out[0];
  endproperty
  a_tristate: assert property (p_tristate) else $error("tristate pin driven");

  property p_open_drain;
    s.mode[1:0] == MODE_OD |-> !pin_out[0] && pin_oe[0] == !s.dout[0];
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain drives high");

  property p_drive;
    wr_do && {s.awaddr[7:2], 2'b00} == OFS_DRIVE && s.wstrb == 4'hF
      |=> ##1 pin_drive == $past(s.wdata[23:0], 2);
  endproperty
  a_drive: assert property (p_drive) else $error("drive strength not applied");

  property p_no_spurious;
    !ev[0] && !s.pend[0] |=> !s.pend[0];
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("pending set without edge");

  property p_set_wins;
    ev[0] |=> s.pend[0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("edge lost");

  property p_wake;
    s.sleep && |ev |=> !low_power;
  endproperty
  a_wake: assert property (p_wake) else $error("edge did not wake");

  property p_irq;
    ev[0] && s.mask[0] |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("unmasked edge gave no interrupt");

  property p_keep;
    !wr_do |=> $stable(s.mode) && $stable(s.pull) && $stable(s.drive) && $stable(s.dout);
  endproperty
  a_keep: assert property (p_keep) else $error("configuration changed without command");

  property p_dbg_data;
    !s.dbg_rel |-> pin_pull_up[PIN_DBG_DATA] && !pin_pull_down[PIN_DBG_DATA];
  endproperty
  a_dbg_data: assert property (p_dbg_data) else $error("debug data pin not pulled up");

  property p_dbg_clk;
    !s.dbg_rel |-> !pin_oe[PIN_DBG_CLK] && pin_pull_down[PIN_DBG_CLK];
  endproperty
  a_dbg_clk: assert property (p_dbg_clk) else $error("debug clock pin driven");

  property p_release;
    s.dbg_rel && s.mode[21:20] == MODE_PP |-> pin_oe[PIN_DBG_DATA];
  endproperty
  a_release: assert property (p_release) else $error("released pin not general I/O");

  c_write: cover property (s.bvalid && bready);
  c_read_status: cover property (arvalid && arready && araddr[7:0] == OFS_STATUS);
  c_wake: cover property (s.sleep ##1 !s.sleep);
  c_release: cover property (!s.dbg_rel ##1 s.dbg_rel);
endmodule

//--- sim/mpcp_board.sv
// board model: pad levels from block drive, external drivers and pull resistors
`timescale 1ns/10ps
module mpcp_board (
  input  wire logic        clk,
  input  wire logic [11:0] pin_out,
  input  wire logic [11:0] pin_oe,
  input  wire logic [11:0] pin_pull_up,
  input  wire logic [11:0] pin_pull_down,
  input  wire logic [11:0] ext_val,
  input  wire logic [11:0] ext_en,
  output logic      [11:0] pin_in
);
  logic [11:0] last = 12'h000;
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pin_pull_up[i]) pin_in[i] = 1'h1;
      else if (pin_pull_down[i]) pin_in[i] = 1'h0;
      // floating pad holds nothing, so show the inverse of the last level
      else pin_in[i] = ~last[i];
    end
  end
  always @(posedge clk) last <= pin_in;
endmodule

//--- sim/module_pin_config_port_bench.sv
// self-checking bench of the pin configuration port
`timescale 1ns/10ps
module module_pin_config_port_bench;
  import mpcp_pkg::*;
  logic        clk, reset_n, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, swd_dio_out, swd_dio_oe;
  logic        swd_dio_in, swd_clk_in, low_power, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, seed, t;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [11:0] pin_in, pin_out, pin_oe, pin_pull_up, pin_pull_down, ext_val, ext_en, dout;
  logic [23:0] pin_drive, mode, pull, drv, e;
  logic [1:0]  bq[$];
  logic [33:0] rq[$];
  int          n_fail, checked;

  mpcp_top #(.FILT_LEN(3)) mpcp_top_i (.clk, .reset_n, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .pin_in, .pin_out, .pin_oe, .pin_pull_up, .pin_pull_down,
    .pin_drive, .swd_dio_out, .swd_dio_oe, .swd_dio_in, .swd_clk_in, .low_power, .irq);
  mpcp_board mpcp_board_i (.clk, .pin_out, .pin_oe, .pin_pull_up, .pin_pull_down, .ext_val,
    .ext_en, .pin_in);

  always #25 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // expected {oe, out} per pin from mode and output value
  function automatic logic [23:0] pads(input logic [23:0] m, input logic [11:0] d);
    logic [23:0] r;
    r = 24'h00_0000;
    for (int i = 0; i < 12; i++) begin
      if (m[2*i+:2] == MODE_PP) r[12+i] = 1'h1;
      if (m[2*i+:2] == MODE_PP) r[i] = d[i];
      if (m[2*i+:2] == MODE_OD) r[12+i] = ~d[i];
    end
    return r;
  endfunction

  // expected {pull up, pull down} per pin
  function automatic logic [23:0] pulls(input logic [23:0] p);
    logic [23:0] r;
    for (int i = 0; i < 12; i++) begin
      r[12+i] = (p[2*i+:2] == PULL_UP);
      r[i] = (p[2*i+:2] == PULL_DN);
    end
    return r;
  endfunction

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // handshakes are judged before the edge and acted on right after it
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic ta, tw, bv;
    @(posedge clk);
    bq.push_back(er);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      bv = bvalid && bready;
      @(posedge clk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
    end while (!bv);
    bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] ex);
    logic ta, rv;
    @(posedge clk);
    rq.push_back(ex);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(negedge clk);
      ta = arvalid && arready;
      rv = rvalid && rready;
      @(posedge clk);
      if (ta) arvalid <= 1'h0;
    end while (!rv);
    rready <= 1'h0;
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic wait_pin();
    repeat (15) @(posedge clk);
    @(negedge clk);
  endtask

  // response monitor takes the oldest note whenever an answer is accepted
  always @(negedge clk) begin
    if (bvalid && bready) chk(bresp, bq.pop_front());
    if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    give_verdict();
  end

  initial begin
    {clk, reset_n, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
    {swd_dio_out, swd_dio_oe, awaddr, araddr, wdata, wstrb} = 54'h0;
    ext_val = 12'h000;
    ext_en = 12'h01F;
    seed = 32'h0000_1F31;
    repeat (5) @(posedge clk);
    @(negedge clk);
    chk({pin_oe, pin_out}, 24'h00_0000);
    chk({pin_pull_up, pin_pull_down, pin_drive}, {12'h400, 12'h800, 24'h00_0000});
    chk({irq, low_power}, 2'h0);
    repeat (5) @(posedge clk);
    reset_n <= 1'h1;
    // random pin setup, read back and check at the pads
    mode = 24'(rnd());
    t = rnd();
    pull = 24'((t & ~(t >> 1) & 32'h0055_5555) | (t & 32'h00AA_AAAA));
    drv = 24'(rnd());
    t = rnd();
    dout = t[11:0];
    wr(OFS_MODE, {8'h00, mode}, 4'hF, RESP_OKAY);
    wr(OFS_PULL, {8'h00, pull}, 4'hF, RESP_OKAY);
    wr(OFS_DRIVE, {8'h00, drv}, 4'hF, RESP_OKAY);
    wr(OFS_DOUT, {20'h0_0000, dout}, 4'hF, RESP_OKAY);
    rd(OFS_MODE, {RESP_OKAY, 8'h00, mode});
    rd(OFS_PULL, {RESP_OKAY, 8'h00, pull});
    rd(OFS_DRIVE, {RESP_OKAY, 8'h00, drv});
    settle();
    e = pads(mode, dout);
    chk({pin_oe[9:0], pin_out[9:0]}, {e[21:12], e[9:0]});
    e = pulls(pull);
    chk({pin_pull_up[9:0], pin_pull_down[9:0]}, {e[21:12], e[9:0]});
    chk(pin_drive[19:0], drv[19:0]);
    // only the strobed byte lane changes
    wr(OFS_DOUT, 32'hFFFF_FFFF, 4'h2, RESP_OKAY);
    dout = {4'hF, dout[7:0]};
    rd(OFS_DOUT, {RESP_OKAY, 20'h0_0000, dout});
    wr(8'h30, 32'h1234_5678, 4'hF, RESP_SLVERR);
    rd(8'h30, {RESP_SLVERR, 32'h0000_0000});
    // edges: pin0 rise, pin1 fall, pin2 both, pin3 off, pin4 both filtered
    mode = {mode[23:10], 10'h155};
    wr(OFS_MODE, {8'h00, mode}, 4'hF, RESP_OKAY);
    wr(OFS_EDGE, 32'h0000_0339, 4'hF, RESP_OKAY);
    wr(OFS_FILT, 32'h0000_0010, 4'hF, RESP_OKAY);
    wr(OFS_MASK, 32'h0000_001F, 4'hF, RESP_OKAY);
    rd(OFS_EDGE, {RESP_OKAY, 32'h0000_0339});
    settle();
    rd(OFS_STATUS, {RESP_OKAY, 32'h0000_0000});
    @(posedge clk);
    ext_val <= 12'h01F;
    wait_pin();
    chk(irq, 1'h1);
    rd(OFS_STATUS, {RESP_OKAY, 32'h0000_0015});
    settle();
    chk(irq, 1'h0);
    rd(OFS_STATUS, {RESP_OKAY, 32'h0000_0000});
    wr(OFS_MASK, 32'h0000_0000, 4'hF, RESP_OKAY);
    wr(OFS_LOWPWR, 32'h0000_0001, 4'hF, RESP_OKAY);
    settle();
    chk(low_power, 1'h1);
    e = pads(mode, dout);
    chk({pin_oe[9:0], pin_out[9:0]}, {e[21:12], e[9:0]});
    chk(pin_drive[19:0], drv[19:0]);
    @(posedge clk);
    ext_val <= 12'h000;
    wait_pin();
    chk({irq, low_power}, 2'h0);
    rd(OFS_STATUS, {RESP_OKAY, 32'h0000_0016});
    rd(OFS_LOWPWR, {RESP_OKAY, 32'h0000_0000});
    // one-cycle glitch passes the unfiltered pin only
    @(posedge clk);
    ext_val <= 12'h014;
    @(posedge clk);
    ext_val <= 12'h000;
    wait_pin();
    rd(OFS_STATUS, {RESP_OKAY, 32'h0000_0004});
    // debug ownership, then release to general use
    @(posedge clk);
    swd_dio_oe <= 1'h1;
    swd_dio_out <= 1'h1;
    settle();
    chk({pin_oe[11:10], pin_out[10], swd_clk_in, swd_dio_in}, 5'h0D);
    chk({pin_pull_up[11:10], pin_pull_down[11:10]}, 4'h6);
    wr(OFS_DEBUG, 32'h0000_0001, 4'hF, RESP_OKAY);
    settle();
    e = pads(mode, dout);
    chk({pin_oe, pin_out}, e);
    e = pulls(pull);
    chk({pin_pull_up, pin_pull_down}, e);
    // reset in mid-run restores everything
    @(posedge clk);
    reset_n <= 1'h0;
    @(negedge clk);
    chk({pin_oe, pin_out}, 24'h00_0000);
    chk({pin_pull_up, pin_pull_down, pin_drive}, {12'h400, 12'h800, 24'h00_0000});
    @(posedge clk);
    reset_n <= 1'h1;
    rd(OFS_MODE, {RESP_OKAY, 32'h0000_0000});
    rd(OFS_DEBUG, {RESP_OKAY, 32'h0000_0000});
    give_verdict();
  end
endmodule
